// ==== pcg_top.sv ====
// Peripheral clock gating registers, mode selection and unit fault checks
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pcg_defs.svh"
module pcg_top
    import pcg_pkg::*;
(
    input wire logic clk, // System clock, 100 MHz
    input wire logic rst, // Synchronous reset, high
    input wire logic [11:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall, high
    output logic [1:0] avs_response, // Access answer
    input wire logic sleep_mode, // Core is in sleep
    input wire logic deep_sleep_mode, // Core is in deep sleep
    input wire logic unit_access, // Access to a unit this cycle
    input wire logic [8:0] unit_select, // One-hot target unit
    output logic unit_bus_fault, // Pulse: gated unit was accessed
    output logic [8:0] unit_fault_which, // Unit that faulted
    output logic [8:0] unit_enable, // Unit enabled, level
    output logic [8:0] unit_clk // Gated unit clocks
);
    // ==================================================
    // State

    pcg_bus_t bus_r;
    pcg_bus_t bus_nxt;
    logic [31:0] run0_r;
    logic [31:0] run0_nxt;
    logic [31:0] run1_r;
    logic [31:0] run1_nxt;
    logic [31:0] slp0_r;
    logic [31:0] slp0_nxt;
    logic [31:0] slp1_r;
    logic [31:0] slp1_nxt;
    logic [31:0] dsl0_r;
    logic [31:0] dsl0_nxt;
    logic [31:0] dsl1_r;
    logic [31:0] dsl1_nxt;
    logic [31:0] cfg_r;
    logic [31:0] cfg_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] resp_r;
    logic [1:0] resp_nxt;
    logic wait_r;
    logic wait_nxt;
    logic [8:0] en_r;
    logic [8:0] en_nxt;
    pcg_mode_t mode_r;
    pcg_mode_t mode_nxt;
    logic fault_r;
    logic fault_nxt;
    logic [8:0] which_r;
    logic [8:0] which_nxt;

    // ==================================================
    // Helpers

    // Byte-lane write limited to implemented bits
    function automatic logic [31:0] lane_write(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be,
        input logic [31:0] mask
    );
        logic [31:0] lanes;
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        lane_write = ((old & ~(lanes & mask)) | (wdata & lanes & mask)) & mask;
    endfunction

    // Unit vector from a pair of gating registers
    function automatic logic [8:0] units_of(
        input logic [31:0] reg0,
        input logic [31:0] reg1
    );
        logic [8:0] u;
        u = 9'h000;
        // (R18) Async port 0 enable
        u[PCG_U_ASP0] = reg1[`PCG_BIT_ASP0];
        // (R17) Async port 1 enable
        u[PCG_U_ASP1] = reg1[`PCG_BIT_ASP1];
        // (R16) Sync port enable
        u[PCG_U_SSP0] = reg1[`PCG_BIT_SSP0];
        // (R15) Two-wire port enable
        u[PCG_U_TWI0] = reg1[`PCG_BIT_TWI0];
        // (R14) Timer 0 enable
        u[PCG_U_GPT0] = reg1[`PCG_BIT_GPT0];
        // (R13) Timer 1 enable
        u[PCG_U_GPT1] = reg1[`PCG_BIT_GPT1];
        // (R12) Timer 2 enable
        u[PCG_U_GPT2] = reg1[`PCG_BIT_GPT2];
        // (R11) Comparator enable
        u[PCG_U_COMPARATOR_ZERO_GATE] = reg1[`PCG_BIT_COMPARATOR_ZERO_GATE];
        // (R01) Watchdog enable
        u[PCG_U_WDOG] = reg0[`PCG_BIT_WATCHDOG];
        units_of = u;
    endfunction

    // Address is one of the mapped registers
    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            `PCG_OFS_RUN_CFG, `PCG_OFS_RUN0, `PCG_OFS_RUN1, `PCG_OFS_SLP0,
            `PCG_OFS_SLP1, `PCG_OFS_DSL0, `PCG_OFS_DSL1, `PCG_OFS_STATUS: begin
                is_mapped = 1'b1;
            end
            default: begin
                is_mapped = 1'b0;
            end
        endcase
    endfunction

    // ==================================================
    // Register bus slave

    // One wait state, then answer; write lands on the answering edge
    always_comb begin
        bus_nxt = bus_r;
        wait_nxt = 1'b1;
        rdata_nxt = rdata_r;
        resp_nxt = resp_r;
        run0_nxt = run0_r;
        run1_nxt = run1_r;
        slp0_nxt = slp0_r;
        slp1_nxt = slp1_r;
        dsl0_nxt = dsl0_r;
        dsl1_nxt = dsl1_r;
        cfg_nxt = cfg_r;
        case (bus_r)
            PCG_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_nxt = PCG_BUS_ACK;
                    wait_nxt = 1'b0;
                    resp_nxt = is_mapped(avs_address) ? `PCG_RESP_OKAY : `PCG_RESP_DECERR;
                    // (R03) Reserved bits read zero
                    case (avs_address)
                        `PCG_OFS_RUN_CFG: rdata_nxt = cfg_r & `PCG_MASK_CFG;
                        `PCG_OFS_RUN0: rdata_nxt = run0_r & `PCG_MASK_REG0;
                        `PCG_OFS_RUN1: rdata_nxt = run1_r & `PCG_MASK_REG1;
                        `PCG_OFS_SLP0: rdata_nxt = slp0_r & `PCG_MASK_REG0;
                        `PCG_OFS_SLP1: rdata_nxt = slp1_r & `PCG_MASK_REG1;
                        `PCG_OFS_DSL0: rdata_nxt = dsl0_r & `PCG_MASK_REG0;
                        `PCG_OFS_DSL1: rdata_nxt = dsl1_r & `PCG_MASK_REG1;
                        `PCG_OFS_STATUS: begin
                            rdata_nxt = 32'h0000_0000;
                            rdata_nxt[8:0] = en_r;
                            rdata_nxt[`PCG_STAT_MODE_LSB +: 2] = mode_r;
                        end
                        default: rdata_nxt = 32'h0000_0000;
                    endcase
                    if (avs_write) begin
                        rdata_nxt = 32'h0000_0000;
                    end
                end
            end
            PCG_BUS_ACK: begin
                bus_nxt = PCG_BUS_IDLE;
                wait_nxt = 1'b1;
                if (avs_write) begin
                    // (R05) Run enables written by software
                    case (avs_address)
                        `PCG_OFS_RUN_CFG: begin
                            cfg_nxt = lane_write(cfg_r, avs_writedata, avs_byteenable, `PCG_MASK_CFG);
                        end
                        `PCG_OFS_RUN0: begin
                            run0_nxt = lane_write(run0_r, avs_writedata, avs_byteenable, `PCG_MASK_REG0);
                        end
                        `PCG_OFS_RUN1: begin
                            run1_nxt = lane_write(run1_r, avs_writedata, avs_byteenable, `PCG_MASK_REG1);
                        end
                        `PCG_OFS_SLP0: begin
                            slp0_nxt = lane_write(slp0_r, avs_writedata, avs_byteenable, `PCG_MASK_REG0);
                        end
                        `PCG_OFS_SLP1: begin
                            slp1_nxt = lane_write(slp1_r, avs_writedata, avs_byteenable, `PCG_MASK_REG1);
                        end
                        `PCG_OFS_DSL0: begin
                            dsl0_nxt = lane_write(dsl0_r, avs_writedata, avs_byteenable, `PCG_MASK_REG0);
                        end
                        `PCG_OFS_DSL1: begin
                            dsl1_nxt = lane_write(dsl1_r, avs_writedata, avs_byteenable, `PCG_MASK_REG1);
                        end
                        default: begin
                            cfg_nxt = cfg_r;
                        end
                    endcase
                end
            end
            default: begin
                bus_nxt = PCG_BUS_IDLE;
            end
        endcase
    end

    // Bus and register flip-flops
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_r <= PCG_BUS_IDLE;
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            resp_r <= `PCG_RESP_OKAY;
            // (R07) All units start unclocked
            run0_r <= `PCG_RST_REG0;
            run1_r <= `PCG_RST_REG1;
            slp0_r <= `PCG_RST_REG0;
            slp1_r <= `PCG_RST_REG1;
            dsl0_r <= `PCG_RST_REG0;
            dsl1_r <= `PCG_RST_REG1;
            cfg_r <= `PCG_RST_CFG;
        end else begin
            bus_r <= bus_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            resp_r <= resp_nxt;
            run0_r <= run0_nxt;
            run1_r <= run1_nxt;
            slp0_r <= slp0_nxt;
            slp1_r <= slp1_nxt;
            dsl0_r <= dsl0_nxt;
            dsl1_r <= dsl1_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    // ==================================================
    // Mode selection and effective enables

    // Pick the register set for the current power mode
    always_comb begin
        if (deep_sleep_mode) begin
            mode_nxt = PCG_MODE_DEEP;
        end else if (sleep_mode) begin
            mode_nxt = PCG_MODE_SLEEP;
        end else begin
            mode_nxt = PCG_MODE_RUN;
        end
        // (R09) Mode picks the register set
        case (mode_nxt)
            PCG_MODE_RUN: en_nxt = units_of(run0_r, run1_r);
            PCG_MODE_SLEEP: begin
                // (R10) Sleep set needs auto gating
                en_nxt = cfg_r[`PCG_BIT_AUTO_GATE] ? units_of(slp0_r, slp1_r) : units_of(run0_r, run1_r);
            end
            PCG_MODE_DEEP: begin
                en_nxt = cfg_r[`PCG_BIT_AUTO_GATE] ? units_of(dsl0_r, dsl1_r) : units_of(run0_r, run1_r);
            end
            default: en_nxt = 9'h000;
        endcase
    end

    // Unit access check against the gated state
    always_comb begin
        // (R06) Gated unit access faults
        which_nxt = unit_access ? (unit_select & ~en_r) : 9'h000;
        // (R02) Watchdog included in check
        fault_nxt = |which_nxt;
    end

    // Enable and fault flip-flops
    always_ff @(posedge clk) begin
        if (rst) begin
            en_r <= 9'h000;
            mode_r <= PCG_MODE_RUN;
            fault_r <= 1'b0;
            which_r <= 9'h000;
        end else begin
            en_r <= en_nxt;
            mode_r <= mode_nxt;
            fault_r <= fault_nxt;
            which_r <= which_nxt;
        end
    end

    // ==================================================
    // Unit clock gates

    genvar gi;
    generate
        for (gi = 0; gi < PCG_UNITS; gi++) begin : g_gate
            pcg_clock_gate u_gate (
                .clk(clk),
                .rst(rst),
                .enable(en_r[gi]),
                .gated_clk(unit_clk[gi])
            );
        end
    endgenerate

    // Outputs
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign avs_response = resp_r;
    assign unit_enable = en_r;
    assign unit_bus_fault = fault_r;
    assign unit_fault_which = which_r;
endmodule

// ==== pcg_defs.svh ====
// Constants of the peripheral clock gating block
// Function
// (R01) Deep-sleep enables bit 3 clocks the watchdog; clear leaves it unclocked and disabled.
// (R02) Watchdog access while its clock is off answers with a bus fault.
// (R03) Reserved bits of both gating registers are read-only and read as zero.
// (R04) Software ignores reserved bits and writes them back unchanged on read-modify-write.
// (R05) Each run-mode bit at 0x104 is one unit's clock enable.
// (R06) Access to a unit whose run-mode bit is clear gives a bus fault; the code checks the enable of the register set in force for the current mode.
// (R07) Run-mode gating register resets to all zero, every unit unclocked.
// (R08) Software enables the units it needs before touching them.
// (R09) Run register applies running, sleep register in sleep, deep-sleep register in deep sleep.
// (R10) Sleep registers apply only when the automatic gating bit is set.
// (R11) Bit 24 gates analog comparator 0.
// (R12) Bit 18 gates general-purpose timer 2.
// (R13) Bit 17 gates general-purpose timer 1.
// (R14) Bit 16 gates general-purpose timer 0.
// (R15) Bit 12 gates two-wire port 0.
// (R16) Bit 4 gates synchronous serial port 0.
// (R17) Bit 1 gates asynchronous serial port 1.
// (R18) Bit 0 gates asynchronous serial port 0.
// (R19) Unit clocks pass a glitch-free gate so no pulse is cut short.
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH

// ==================================================
// Register byte offsets
`define PCG_OFS_RUN_CFG 12'h060
`define PCG_OFS_RUN0 12'h100
`define PCG_OFS_RUN1 12'h104
`define PCG_OFS_SLP0 12'h110
`define PCG_OFS_SLP1 12'h114
`define PCG_OFS_DSL0 12'h120
`define PCG_OFS_DSL1 12'h124
`define PCG_OFS_STATUS 12'h130

// ==================================================
// Field positions
`define PCG_BIT_WATCHDOG 3
`define PCG_BIT_COMPARATOR_ZERO_GATE 24
`define PCG_BIT_GPT2 18
`define PCG_BIT_GPT1 17
`define PCG_BIT_GPT0 16
`define PCG_BIT_TWI0 12
`define PCG_BIT_SSP0 4
`define PCG_BIT_ASP1 1
`define PCG_BIT_ASP0 0
`define PCG_BIT_AUTO_GATE 27
`define PCG_STAT_MODE_LSB 16

// ==================================================
// Writable masks and reset values
`define PCG_MASK_REG1 32'h0107_1013
`define PCG_MASK_REG0 32'h0000_0008
`define PCG_MASK_CFG 32'h0800_0000
`define PCG_RST_REG1 32'h0000_0000
`define PCG_RST_REG0 32'h0000_0000
`define PCG_RST_CFG 32'h0000_0000

// ==================================================
// Avalon response codes
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2
`define PCG_RESP_DECERR 2'h3

`endif

// ==== pcg_pkg.sv ====
// Types of the peripheral clock gating block
package pcg_pkg;
    // Number of gated units
    localparam int PCG_UNITS = 9;
    // Unit index order on the unit vectors
    typedef enum logic [3:0] {
        PCG_U_ASP0,
        PCG_U_ASP1,
        PCG_U_SSP0,
        PCG_U_TWI0,
        PCG_U_GPT0,
        PCG_U_GPT1,
        PCG_U_GPT2,
        PCG_U_COMPARATOR_ZERO_GATE,
        PCG_U_WDOG
    } pcg_unit_t;
    // Power mode in force
    typedef enum logic [1:0] {
        PCG_MODE_RUN,
        PCG_MODE_SLEEP,
        PCG_MODE_DEEP
    } pcg_mode_t;
    // Bus slave states
    typedef enum logic {
        PCG_BUS_IDLE,
        PCG_BUS_ACK
    } pcg_bus_t;
endpackage

// ==== pcg_clock_gate.sv ====
// Glitch-free clock gate for one unit
`timescale 1ns/1ps
module pcg_clock_gate (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic enable, // Gate enable, clk domain
    output logic gated_clk // Gated unit clock
);
    logic en_low_r;
    logic en_low_nxt;

    // Enable only changes while clk is low
    always_comb begin
        en_low_nxt = rst ? 1'b0 : enable;
    end

    // (R19) Falling-edge enable capture
    always_ff @(negedge clk) begin
        en_low_r <= en_low_nxt;
    end

    // Clock passes only in whole high phases
    assign gated_clk = clk & en_low_r;
endmodule

// ==== pcg_top_sva.sv ====
// Port assertions for the clock gating block
`timescale 1ns/1ps
module pcg_top_sva
    import pcg_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic [11:0] avs_address, // Address
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [31:0] avs_writedata, // Wdata
    input wire logic [3:0] avs_byteenable, // Lanes
    input wire logic [31:0] avs_readdata, // Rdata
    input wire logic avs_waitrequest, // Stall
    input wire logic [1:0] avs_response, // Answer
    input wire logic sleep_mode, // Sleep
    input wire logic deep_sleep_mode, // Deep sleep
    input wire logic unit_access, // Unit access
    input wire logic [8:0] unit_select, // Target
    input wire logic unit_bus_fault, // Fault
    input wire logic [8:0] unit_fault_which, // Faulting unit
    input wire logic [8:0] unit_enable, // Enables
    input wire logic [8:0] unit_clk // Unit clocks
);
    // ==========
    // Helpers
    logic req;
    logic [8:0] off;
    logic [7:0] run_bits;
    // Request taken, disabled targets, gating bits of a write
    assign req = (avs_read || avs_write) && avs_waitrequest;
    assign off = unit_select & ~unit_enable;
    assign run_bits = {avs_writedata[24], avs_writedata[18:16], avs_writedata[12], avs_writedata[4], avs_writedata[1:0]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========
    // Assertions
    // reset clears enables
    property p_rst;
        disable iff (1'b0) rst |=> unit_enable == 9'h000 && avs_waitrequest && !unit_bus_fault;
    endproperty
    a_rst: assert property (p_rst) else $error("enables not clear after reset");
    property p_fault;
        unit_access && |off |=> unit_bus_fault && unit_fault_which == $past(off);
    endproperty
    a_fault: assert property (p_fault) else $error("missing unit fault");
    property p_nofault;
        !(unit_access && |off) |=> !unit_bus_fault;
    endproperty
    a_nofault: assert property (p_nofault) else $error("spurious unit fault");
    property p_wdog;
        unit_access && unit_select[8] && !unit_enable[8] |=> unit_fault_which[8];
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog access not faulted");
    property p_take;
        req |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_take: assert property (p_take) else $error("bus answer timing wrong");
    property p_cause;
        !avs_waitrequest |-> $past(avs_read || avs_write);
    endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_unmapped;
        req && !(avs_address inside {12'h060, 12'h100, 12'h104, 12'h110, 12'h114, 12'h120, 12'h124, 12'h130})
            |=> avs_response == 2'h3 && avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access answered wrongly");
    property p_resv;
        req && avs_read && avs_address inside {12'h104, 12'h120}
            |=> (avs_readdata & ~((avs_address == 12'h104) ? 32'h0107_1013 : 32'h0000_0008)) == 32'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
    // run write drives enables, register lands then enables follow one edge later
    property p_run_wr;
        avs_write && !avs_waitrequest && avs_address == 12'h104 && avs_byteenable == 4'hf && !sleep_mode
            && !deep_sleep_mode |=> ##1 unit_enable[7:0] == $past(run_bits, 2);
    endproperty
    a_run_wr: assert property (p_run_wr) else $error("run write not applied");
endmodule

// ==== pcg_top_tb.sv ====
// Self-checking bench for the clock gating block
`timescale 1ns/1ps
module pcg_top_tb
    import pcg_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic sleep_mode = 1'b0;
    logic deep_sleep_mode = 1'b0;
    logic unit_access = 1'b0;
    logic [8:0] unit_select = 9'h000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic unit_bus_fault;
    logic [8:0] unit_fault_which;
    logic [8:0] unit_enable;
    logic [8:0] unit_clk;
    int n_errors = 0;
    int checks = 0;
    int pos [8] = '{0, 1, 4, 12, 16, 17, 18, 24};
    // Clock
    always #5 clk = ~clk;
    pcg_top u_pcg_top (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .avs_response, .sleep_mode, .deep_sleep_mode, .unit_access,
        .unit_select, .unit_bus_fault, .unit_fault_which, .unit_enable, .unit_clk);
    // ==========
    // Shared tasks
    task automatic stop_test();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bus cycle held until waitrequest is seen low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b,
        output logic [31:0] q, output logic [1:0] r);
        logic done = 1'b0;
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= b;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) begin
                done = 1'b1;
                q = avs_readdata;
                r = avs_response;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (!done) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b1, a, d, b, q, r);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b0, a, 32'h0, 4'hf, q, r);
        cmp(q, e);
        cmp(r, er);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One access cycle to units, fault checked next cycle
    task automatic utry(input logic [8:0] s, input logic [8:0] e);
        @(posedge clk);
        unit_access <= 1'b1;
        unit_select <= s;
        @(posedge clk);
        unit_access <= 1'b0;
        #1;
        cmp(unit_bus_fault, |e);
        cmp(unit_fault_which, e);
    endtask
    // Gated clocks high only in the high phase of enabled units
    task automatic cchk(input logic [8:0] e);
        @(posedge clk);
        #2;
        cmp(unit_clk, e);
        @(negedge clk);
        #2;
        cmp(unit_clk, 9'h000);
    endtask
    // ==========
    // Scenarios
    task automatic t_reset();
        rchk(12'h104, 32'h0);
        rchk(12'h120, 32'h0);
        cmp(unit_enable, 9'h000);
        utry(9'h1ff, 9'h1ff);
        cchk(9'h000);
        rchk(12'h200, 32'h0, 2'h3);
    endtask
    task automatic t_bits();
        for (int i = 0; i < 8; i++) begin
            wreg(12'h104, 32'h1 << pos[i]);
            tick(1);
            cmp(unit_enable, 9'h1 << i);
            cchk(9'h1 << i);
            utry(9'h0ff, 9'h0ff & ~(9'h1 << i));
        end
    endtask
    task automatic t_resv();
        wreg(12'h104, 32'hffff_ffff);
        rchk(12'h104, 32'h0107_1013);
        wreg(12'h104, 32'h0, 4'h4);
        rchk(12'h104, 32'h0100_1013);
        wreg(12'h104, 32'h0100_1013 | 32'h0007_0000);
        rchk(12'h104, 32'h0107_1013);
        wreg(12'h120, 32'hffff_ffff);
        rchk(12'h120, 32'h0000_0008);
        utry(9'h100, 9'h100);
        wreg(12'h100, 32'h8);
        tick(1);
        cmp(unit_enable, 9'h1ff);
        utry(9'h100, 9'h000);
    endtask
    task automatic t_modes();
        wreg(12'h060, 32'h0800_0000);
        rchk(12'h060, 32'h0800_0000);
        wreg(12'h124, 32'h0000_0011);
        wreg(12'h114, 32'h0000_1000);
        @(posedge clk);
        deep_sleep_mode <= 1'b1;
        tick(2);
        cmp(unit_enable, 9'h105);
        rchk(12'h130, 32'h0002_0105);
        wreg(12'h120, 32'h0);
        tick(1);
        cmp(unit_enable, 9'h005);
        utry(9'h100, 9'h100);
        @(posedge clk);
        deep_sleep_mode <= 1'b0;
        sleep_mode <= 1'b1;
        tick(2);
        cmp(unit_enable, 9'h008);
        wreg(12'h060, 32'h0);
        tick(1);
        cmp(unit_enable, 9'h1ff);
        @(posedge clk);
        sleep_mode <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        cmp(unit_enable, 9'h000);
        rchk(12'h100, 32'h0);
    endtask
    // ==========
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_bits();
        t_resv();
        t_modes();
        stop_test();
    end
endmodule
bind pcg_top pcg_top_sva u_pcg_top_sva (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .sleep_mode, .deep_sleep_mode,
    .unit_access, .unit_select, .unit_bus_fault, .unit_fault_which, .unit_enable, .unit_clk);
